// [pkg/reset_delay_pkg.sv]
// Timing constants and clock source codes for the reset delay sequencer
package reset_delay_pkg;

    // ************************************************************
    // Clock and delay times
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 40;
    localparam int T_POR_US         = 10;
    localparam int T_START_ON_US    = 20;
    localparam int T_START_OFF_MS   = 64;
    localparam int T_RST_US         = 20;
    localparam int T_LOCK_US        = 20;
    localparam int T_MON_US         = 100;

    // Least times round up to whole cycles
    localparam int POR_CYCLES       = (T_POR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_ON_CYCLES  = (T_START_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_OFF_CYCLES =
        (T_START_OFF_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYCLES       = (T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CYCLES      = (T_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MON_CYCLES       = (T_MON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W            = 21;
    localparam int OST_W            = 10;

    // ************************************************************
    // Clock source codes
    // ************************************************************
    localparam logic [3:0] SRC_EXT_CLOCK                  = 4'h0;
    localparam logic [3:0] SRC_FAST_INTERNAL_RC_OSC       = 4'h1;
    localparam logic [3:0] SRC_LOW_POWER_INTERNAL_RC_OSC  = 4'h2;
    localparam logic [3:0] SRC_EXTERNAL_CLOCK_WITH_PLL    = 4'h3;
    localparam logic [3:0] SRC_INTERNAL_RC_WITH_PLL       = 4'h4;
    localparam logic [3:0] SRC_CRYSTAL                    = 4'h5;
    localparam logic [3:0] SRC_HIGH_SPEED_CRYSTAL         = 4'h6;
    localparam logic [3:0] SRC_SECONDARY_OSC              = 4'h7;
    localparam logic [3:0] SRC_CRYSTAL_WITH_PLL           = 4'h8;
    localparam logic [3:0] SRC_HIGH_SPEED_CRYSTAL_WITH_PLL = 4'h9;

    typedef enum logic [2:0] {
        S_POR,
        S_START,
        S_RST,
        S_WAKE,
        S_RUN
    } seq_state_e;

endpackage

// [hw/reset_delay_sequencer.sv]
// Reset release sequencer with clock gating and clock monitor start-up
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// R1: Power-on holds reset for por+startup+state time
// R2: Power-on delay of 10 us comes first
// R3: Startup 20 us regulator on, 64 ms off
// R4: Regulator on: startup delay on every wake
// R5: Other resets hold only the 20 us
// R6: Brown-out omits power-on delay, else like power-on
// R7: Clock release waits per source for timer/lock
// R8: Start-up timer counts 1024 oscillator periods
// R9: PLL usable 20 us after lock
// R10: Clock timing independent; no run without clock
// R11: Crystal/PLL: monitor delay after power-up delays
// R12: Monitor starts at release; fails to fast RC, trap
module reset_delay_sequencer
    import reset_delay_pkg::*;
#(
    parameter int START_OFF_CNT = START_OFF_CYCLES,
    parameter int MON_CNT       = MON_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       brown_out_i,
    input  wire logic       external_clear_pin_n_i,
    input  wire logic       watchdog_i,
    input  wire logic       software_reset_i,
    input  wire logic       illegal_opcode_i,
    input  wire logic       uninit_register_i,
    input  wire logic       trap_conflict_i,
    input  wire logic       wake_i,
    input  wire logic       regulator_en_i,
    input  wire logic [3:0] clock_source_i,
    input  wire logic       osc_clk_i,
    input  wire logic       pll_lock_i,
    input  wire logic       fail_safe_clock_monitor_en_i,
    input  wire logic       clock_valid_i,
    output logic            internal_system_reset_o,
    output logic            clock_release_o,
    output logic            monitor_active_o,
    output logic            fast_internal_rc_osc_sel_o,
    output logic            clock_fail_trap_o
);

    // ************************************************************
    // Source decoding
    // ************************************************************
    function automatic logic needs_ost(input logic [3:0] src);
        needs_ost = (src == SRC_CRYSTAL) || (src == SRC_HIGH_SPEED_CRYSTAL) ||
                    (src == SRC_SECONDARY_OSC) || (src == SRC_CRYSTAL_WITH_PLL) ||
                    (src == SRC_HIGH_SPEED_CRYSTAL_WITH_PLL);
    endfunction

    function automatic logic needs_pll(input logic [3:0] src);
        needs_pll = (src == SRC_EXTERNAL_CLOCK_WITH_PLL) ||
                    (src == SRC_INTERNAL_RC_WITH_PLL) || (src == SRC_CRYSTAL_WITH_PLL) ||
                    (src == SRC_HIGH_SPEED_CRYSTAL_WITH_PLL);
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] clr_sync_q;
    logic [2:0] osc_sync_q;
    logic [1:0] lock_sync_q;
    logic [1:0] valid_sync_q;

    always_ff @(posedge clk_i) begin
        clr_sync_q   <= {clr_sync_q[0], ~external_clear_pin_n_i};
        osc_sync_q   <= {osc_sync_q[1:0], osc_clk_i};
        lock_sync_q  <= {lock_sync_q[0], pll_lock_i};
        valid_sync_q <= {valid_sync_q[0], clock_valid_i};
    end

    wire osc_tick    = osc_sync_q[1] & ~osc_sync_q[2];
    wire soft_cause  = clr_sync_q[1] | watchdog_i | software_reset_i | illegal_opcode_i |
                       uninit_register_i | trap_conflict_i;
    wire src_ost     = needs_ost(clock_source_i);
    wire src_pll     = needs_pll(clock_source_i);

    // ************************************************************
    // Reset release sequence
    // ************************************************************
    seq_state_e       state_q;
    seq_state_e       state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             power_q;

    wire [CNT_W-1:0] start_load = regulator_en_i ? CNT_W'(START_ON_CYCLES - 1)   // [R3]
                                                 : CNT_W'(START_OFF_CNT - 1);
    wire             cnt_done   = (cnt_q == '0);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
        if (brown_out_i) begin
            state_d = S_START;                                  // [R6]
            cnt_d   = start_load;
        end else if (soft_cause) begin
            state_d = S_RST;                                    // [R5]
            cnt_d   = CNT_W'(RST_CYCLES - 1);
        end else if (cnt_done) begin
            case (state_q)
                S_POR: begin
                    state_d = S_START;                          // [R1]
                    cnt_d   = start_load;
                end
                S_START: begin
                    state_d = S_RST;                            // [R1]
                    cnt_d   = CNT_W'(RST_CYCLES - 1);
                end
                S_RST:   state_d = S_RUN;
                S_WAKE:  state_d = S_RUN;
                S_RUN: begin
                    if (wake_i && regulator_en_i) begin
                        state_d = S_WAKE;                       // [R4]
                        cnt_d   = CNT_W'(START_ON_CYCLES - 1);
                    end
                end
                default: state_d = S_POR;
            endcase
        end
    end

    wire in_reset_d = (state_d == S_POR) || (state_d == S_START) || (state_d == S_RST);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q                 <= S_POR;                   // [R2]
            cnt_q                   <= CNT_W'(POR_CYCLES - 1);
            internal_system_reset_o <= 1'b1;
            power_q                 <= 1'b1;
        end else begin
            state_q                 <= state_d;
            cnt_q                   <= cnt_d;
            internal_system_reset_o <= in_reset_d;
            power_q                 <= brown_out_i | (power_q & in_reset_d);
        end
    end

    // ************************************************************
    // Clock release, independent of the reset timing
    // ************************************************************
    // Only power events restart the oscillator; other resets keep the clock running
    logic [OST_W-1:0] ost_cnt_q;
    logic             ost_done_q;
    logic [CNT_W-1:0] lock_cnt_q;
    logic             lock_done_q;

    wire lock_hit   = (lock_cnt_q == CNT_W'(LOCK_CYCLES - 1));
    wire clk_ok_d   = (~src_ost | ost_done_q) & (~src_pll | lock_done_q);   // [R7]
    wire stall_d    = (state_d == S_WAKE);

    always_ff @(posedge clk_i) begin
        if (reset_i || brown_out_i) begin
            ost_cnt_q   <= '0;
            ost_done_q  <= 1'b0;
            lock_cnt_q  <= '0;
            lock_done_q <= 1'b0;
            clock_release_o <= 1'b0;
        end else begin
            if (osc_tick && !ost_done_q) begin
                ost_cnt_q  <= ost_cnt_q + OST_W'(1);            // [R8]
                ost_done_q <= (ost_cnt_q == '1);
            end
            if (!lock_sync_q[1]) begin
                lock_cnt_q  <= '0;
                lock_done_q <= 1'b0;
            end else if (!lock_done_q) begin
                lock_cnt_q  <= lock_cnt_q + CNT_W'(1);          // [R9]
                lock_done_q <= lock_hit;
            end
            // Code may run only with a released clock, whatever the reset does
            clock_release_o <= clk_ok_d & ~stall_d;             // [R10]
        end
    end

    // ************************************************************
    // Fail-safe clock monitor start
    // ************************************************************
    logic [CNT_W-1:0] mon_cnt_q;
    logic             mon_wait_q;

    wire release_now = internal_system_reset_o & ~in_reset_d;
    wire mon_delay   = power_q & (src_ost | src_pll);

    always_ff @(posedge clk_i) begin
        if (reset_i || in_reset_d) begin
            mon_cnt_q        <= '0;
            mon_wait_q       <= 1'b0;
            monitor_active_o <= 1'b0;
        end else if (release_now) begin
            mon_cnt_q        <= CNT_W'(MON_CNT - 1);            // [R11]
            mon_wait_q       <= mon_delay;
            monitor_active_o <= fail_safe_clock_monitor_en_i & ~mon_delay;   // [R12]
        end else if (mon_wait_q) begin
            mon_cnt_q        <= mon_cnt_q - CNT_W'(1);
            mon_wait_q       <= (mon_cnt_q != '0);
            monitor_active_o <= fail_safe_clock_monitor_en_i & (mon_cnt_q == '0);
        end else begin
            monitor_active_o <= monitor_active_o & fail_safe_clock_monitor_en_i;
        end
    end

    // Selection stays on the fast RC until the next power event
    always_ff @(posedge clk_i) begin
        if (reset_i || brown_out_i) begin
            fast_internal_rc_osc_sel_o <= 1'b0;
            clock_fail_trap_o          <= 1'b0;
        end else begin
            clock_fail_trap_o <= monitor_active_o & ~valid_sync_q[1] &
                                 ~fast_internal_rc_osc_sel_o;   // [R12]
            if (monitor_active_o && !valid_sync_q[1]) begin
                fast_internal_rc_osc_sel_o <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_por_reset_held: assert property ($fell(reset_i) |-> internal_system_reset_o[*8]) // [R1]
        else $error("Reset not held after power-on");
    chk_por_first: assert property ($fell(reset_i) |-> state_q == S_POR) // [R2]
        else $error("Power-on delay not first");
    chk_start_load: assert property ( // [R3]
        state_q == S_POR && cnt_done && !brown_out_i && !soft_cause |=>
        state_q == S_START &&
        cnt_q == ($past(regulator_en_i) ? CNT_W'(START_ON_CYCLES - 1) : CNT_W'(START_OFF_CNT - 1)))
        else $error("Start-up delay load wrong");
    chk_wake_stall: assert property ( // [R4]
        state_q == S_RUN && wake_i && regulator_en_i && !brown_out_i && !soft_cause |=>
        state_q == S_WAKE ##1 !clock_release_o)
        else $error("Wake did not stall clock");
    chk_soft_only_rst: assert property ( // [R5]
        soft_cause && !brown_out_i |=> state_q == S_RST && cnt_q == CNT_W'(RST_CYCLES - 1)
        && internal_system_reset_o)
        else $error("Soft reset delay wrong");
    chk_bor_skips_por: assert property (brown_out_i |=> state_q == S_START) // [R6]
        else $error("Brown-out entered power-on delay");
    chk_ost_gate: assert property (src_ost && !ost_done_q |=> !clock_release_o) // [R7] [R8]
        else $error("Clock released before start-up timer");
    chk_lock_gate: assert property (src_pll && !lock_sync_q[1] |=> ##1 !clock_release_o) // [R9]
        else $error("Clock released without lock");
    chk_mon_wait: assert property ($rose(mon_wait_q) |-> !monitor_active_o[*8]) // [R11]
        else $error("Monitor started during delay");
    chk_fail_switch: assert property ( // [R12]
        monitor_active_o && !valid_sync_q[1] && !fast_internal_rc_osc_sel_o && !brown_out_i |=>
        fast_internal_rc_osc_sel_o && clock_fail_trap_o)
        else $error("Clock failure not handled");

endmodule

`default_nettype wire

// [tb/clock_partner.sv]
// Oscillator, PLL lock and clock-valid model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module clock_partner (
    input  wire logic clk_i,
    input  wire logic osc_run_i,
    input  wire logic fail_i,
    output logic      osc_clk_o,
    output logic      pll_lock_o,
    output logic      clock_valid_o
);
    logic [1:0] div_q;
    int         lock_q;
    // Oscillator runs at a quarter of clk_i and stands still when stopped
    always_ff @(posedge clk_i) begin
        div_q  <= osc_run_i ? div_q + 2'h1 : 2'h0;
        lock_q <= osc_run_i ? lock_q + 1 : 0;
    end
    assign osc_clk_o     = div_q[1];
    // The loop needs some time of its own before it reports lock
    assign pll_lock_o    = lock_q > 100;
    assign clock_valid_o = osc_run_i & ~fail_i;
endmodule
`default_nettype wire

// [tb/tb_reset_delay_sequencer.sv]
// Self-checking bench for the reset delay sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_reset_delay_sequencer import reset_delay_pkg::*;;
    localparam int START_OFF = 40;
    localparam int MON       = 20;
    localparam int OSC_DIV   = 4;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       brown_out_i = 1'b0;
    logic       clear_n = 1'b1;
    logic       wake_i = 1'b0;
    logic [4:0] soft_q = 5'h00;
    logic       reg_en = 1'b1;
    logic       fail_safe_clock_monitor_en = 1'b1;
    logic       osc_run = 1'b0;
    logic       fail = 1'b0;
    logic [3:0] src = SRC_EXT_CLOCK;
    logic       osc_clk, pll_lock, clk_valid;
    logic       rst_o, clk_rel, mon_act, frc_sel, trap_o;
    int         miscompares = 0;
    int         tests_run = 0;

    always #20 clk_i = ~clk_i;

    reset_delay_sequencer #(.START_OFF_CNT(START_OFF), .MON_CNT(MON)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .brown_out_i(brown_out_i),
        .external_clear_pin_n_i(clear_n), .watchdog_i(soft_q[0]),
        .software_reset_i(soft_q[1]), .illegal_opcode_i(soft_q[2]),
        .uninit_register_i(soft_q[3]), .trap_conflict_i(soft_q[4]),
        .wake_i(wake_i), .regulator_en_i(reg_en), .clock_source_i(src),
        .osc_clk_i(osc_clk), .pll_lock_i(pll_lock),
        .fail_safe_clock_monitor_en_i(fail_safe_clock_monitor_en), .clock_valid_i(clk_valid),
        .internal_system_reset_o(rst_o), .clock_release_o(clk_rel),
        .monitor_active_o(mon_act), .fast_internal_rc_osc_sel_o(frc_sel),
        .clock_fail_trap_o(trap_o));

    clock_partner partner (.clk_i(clk_i), .osc_run_i(osc_run), .fail_i(fail),
        .osc_clk_o(osc_clk), .pll_lock_o(pll_lock), .clock_valid_o(clk_valid));

    // ************************************************************
    // Compare and drive helpers
    // ************************************************************
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Counts edges until the picked output shows lvl; gives up at max
    task automatic wait_out(input int sel, input logic lvl, input int max, output int n);
        logic v;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            v = sel == 0 ? rst_o : sel == 1 ? clk_rel : sel == 2 ? mon_act : trap_o;
        end while (v !== lvl && n < max);
    endtask

    // One-cycle cause: 0 clear pin, 1..5 soft causes, 6 brown-out, 7 wake
    task automatic pulse_cause(input int k);
        @(posedge clk_i);
        if (k == 0) clear_n <= 1'b0;
        else if (k < 6) soft_q[k-1] <= 1'b1;
        else if (k == 6) brown_out_i <= 1'b1;
        else wake_i <= 1'b1;
        @(posedge clk_i);
        clear_n <= 1'b1;
        soft_q <= 5'h00;
        brown_out_i <= 1'b0;
        wake_i <= 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic power_on(input logic reg_on, input logic [3:0] s, input int rst_n,
                            input logic clk_at, input int clk_lo, input int clk_hi,
                            input int mon_n);
        int n, m, c;
        @(posedge clk_i);
        reg_en <= reg_on;
        src <= s;
        reset_i <= 1'b1;
        // Supply loss stops the oscillator, so lock must be found again
        osc_run <= 1'b0;
        repeat (4) @(posedge clk_i);
        check_bit(frc_sel, 1'b0);
        reset_i <= 1'b0;
        osc_run <= 1'b1;
        wait_out(0, 1'b0, rst_n + 10, n);
        check_count(n, rst_n - 2, rst_n + 2);
        check_bit(clk_rel, clk_at);
        wait_out(2, 1'b1, mon_n + 10, m);
        check_count(m, mon_n - 1, mon_n + 1);
        wait_out(1, 1'b1, clk_hi + 10, c);
        check_count(n + m + c, clk_lo, clk_hi);
    endtask

    task automatic soft_resets();
        int n, m, e;
        for (int k = 0; k < 6; k++) begin
            e = RST_CYCLES + 1 + (k == 0 ? 2 : 0);
            pulse_cause(k);
            wait_out(0, 1'b1, 6, n);
            check_count(n, 1, 4);
            wait_out(0, 1'b0, e + 10, m);
            check_count(n + m, e - 1, e + 1);
            check_bit(clk_rel, 1'b1);
        end
    endtask

    task automatic brown_out_reset();
        int n, e;
        e = START_ON_CYCLES + RST_CYCLES + 1;
        pulse_cause(6);
        wait_out(0, 1'b0, e + 10, n);
        check_count(n, e - 2, e + 2);
    endtask

    task automatic wake_stall();
        int n, m;
        pulse_cause(7);
        wait_out(1, 1'b0, 4, n);
        check_count(n, 1, 3);
        wait_out(1, 1'b1, START_ON_CYCLES + 10, m);
        check_count(n + m, START_ON_CYCLES - 1, START_ON_CYCLES + 3);
        check_bit(rst_o, 1'b0);
        // With the regulator off a wake must not stall the clock
        reg_en <= 1'b0;
        pulse_cause(7);
        repeat (8) @(posedge clk_i);
        check_bit(clk_rel, 1'b1);
    endtask

    task automatic clock_failure();
        int n;
        // Monitor switched off: a lost clock must go unnoticed
        @(posedge clk_i);
        fail_safe_clock_monitor_en <= 1'b0;
        fail <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        check_bit(mon_act, 1'b0);
        check_bit(trap_o, 1'b0);
        check_bit(frc_sel, 1'b0);
        @(posedge clk_i);
        fail <= 1'b0;
        fail_safe_clock_monitor_en <= 1'b1;
        // The next release with the monitor enabled starts it again
        pulse_cause(1);
        wait_out(0, 1'b1, 6, n);
        wait_out(0, 1'b0, RST_CYCLES + 10, n);
        check_bit(mon_act, 1'b1);
        @(posedge clk_i);
        fail <= 1'b1;
        wait_out(3, 1'b1, 8, n);
        check_count(n, 2, 5);
        check_bit(frc_sel, 1'b1);
        @(posedge clk_i);
        fail <= 1'b0;
        #1;
        check_bit(trap_o, 1'b0);
        check_bit(frc_sel, 1'b1);
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        osc_run <= 1'b1;
        repeat (14) @(posedge clk_i);
        power_on(1'b1, SRC_EXT_CLOCK, POR_CYCLES + START_ON_CYCLES + RST_CYCLES,
                 1'b1, 0, 99999, 1);
        soft_resets();
        brown_out_reset();
        wake_stall();
        clock_failure();
        power_on(1'b0, SRC_CRYSTAL_WITH_PLL, POR_CYCLES + START_OFF + RST_CYCLES,
                 1'b0, 1024 * OSC_DIV - 4, 1024 * OSC_DIV + 12, MON);
        print_verdict();
    end

    // Run should end near 10.4k cycles; cut a hang well past that
    initial begin
        #(40 * 40000);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
